// ===== accf_pkg.sv
package accf_pkg;
   // result geometry
   localparam int RESULT_W = 56;
   localparam int RESULT_MSB = 55;
   // scaling mode encodings
   localparam logic [1:0] SCALE_NONE = 2'h0;
   localparam logic [1:0] SCALE_DOWN = 2'h1;
   localparam logic [1:0] SCALE_UP = 2'h2;
   // integer portion low bit per mode
   localparam int INT_LO_NONE = 47;
   localparam int INT_LO_DOWN = 48;
   localparam int INT_LO_UP = 46;
   // top pair of the most significant portion (upper bit)
   localparam int MSP_HI_NONE = 47;
   localparam int MSP_HI_DOWN = 48;
   localparam int MSP_HI_UP = 46;
   // saturation widths
   localparam int SAT_W_NORMAL = 48;
   localparam int SAT_W_SIXTEEN = 32;
   // flag positions in the flag vector
   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   localparam int FLAG_U = 4;
   localparam int FLAG_E = 5;
   // flag reset values
   localparam logic [5:0] FLAGS_RESET = 6'h20;
   // carry source select
   typedef enum logic [1:0] {ACCF_CARRY_ARITH, ACCF_CARRY_OTHER, ACCF_CARRY_HOLD} accf_carry_src_t;
endpackage

// ===== accf_flags.sv
`timescale 1ns/1ps
// Operation
// - extension clear when integer portion uniform
// - integer portion bits chosen by scaling mode
// - extension resets to one, others zero
// - unnormalized set when top two bits equal
// - unnormalized bit pair chosen by scaling mode
// - negative follows result sign bit
// - zero set when whole result zero
// - overflow set when result unrepresentable
// - saturation mode overflow at 48/32 bits
// - carry from bit 55 add or borrow
// - carry also from bit, rotate, shift ops
module accf_flags
   import accf_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic flag_update,
   input wire logic [RESULT_W-1:0] alu_result,
   input wire logic scaling_mode_high,
   input wire logic scaling_mode_low,
   input wire logic arith_overflow,
   input wire logic sat_mode,
   input wire logic sixteen_mode,
   input wire logic [RESULT_W:0] pre_sat_result,
   input wire logic carry_out,
   input wire accf_carry_src_t carry_src,
   input wire logic other_carry,
   output logic flag_extension,
   output logic flag_unnormalized,
   output logic flag_negative,
   output logic flag_zero,
   output logic flag_overflow,
   output logic flag_carry
);

   ////////////////////////////////////////////////////////////////////////
   logic [5:0] flags_reg;
   logic [5:0] flags_next;
   logic [1:0] mode;
   logic ext_bit;
   logic unn_bit;
   logic sat_ovf;
   logic carry_bit;
   // per-mode span and pair results
   logic int_flat_none;
   logic int_flat_down;
   logic int_flat_up;
   logic unn_none;
   logic unn_down;
   logic unn_up;
   // saturation fit results
   logic fit_normal;
   logic fit_sixteen;

   // scaling mode code, high bit first
   assign mode = {scaling_mode_high, scaling_mode_low};

   // elaboration checks on the bit positions named in the package
   if (RESULT_MSB != RESULT_W - 1) begin : g_bad_msb
      $error("accf_flags: sign bit is not the top bit of the result");
   end
   if (INT_LO_UP < 1 || INT_LO_DOWN > RESULT_MSB) begin : g_bad_int
      $error("accf_flags: integer portion outside the result");
   end
   if (MSP_HI_UP < 1 || MSP_HI_DOWN > RESULT_MSB) begin : g_bad_pair
      $error("accf_flags: unnormalized pair outside the result");
   end
   if (SAT_W_SIXTEEN < 2 || SAT_W_NORMAL > RESULT_W) begin : g_bad_sat
      $error("accf_flags: saturation width outside the guarded result");
   end

   ////////////////////////////////////////////////////////////////////////
   // integer portion with no scaling: only sign extension when flat
   accf_flat_span #(
      .WIDTH(RESULT_W),
      .LO(INT_LO_NONE)
   ) u_int_none (
      .word(alu_result),
      .flat(int_flat_none)
   );

   // integer portion when scaling down, one bit shorter
   accf_flat_span #(
      .WIDTH(RESULT_W),
      .LO(INT_LO_DOWN)
   ) u_int_down (
      .word(alu_result),
      .flat(int_flat_down)
   );

   // integer portion when scaling up, one bit longer
   accf_flat_span #(
      .WIDTH(RESULT_W),
      .LO(INT_LO_UP)
   ) u_int_up (
      .word(alu_result),
      .flat(int_flat_up)
   );

   // top pair of the most significant portion, one per mode
   assign unn_none = ~(alu_result[MSP_HI_NONE] ^ alu_result[MSP_HI_NONE-1]);
   assign unn_down = ~(alu_result[MSP_HI_DOWN] ^ alu_result[MSP_HI_DOWN-1]);
   assign unn_up = ~(alu_result[MSP_HI_UP] ^ alu_result[MSP_HI_UP-1]);

   ////////////////////////////////////////////////////////////////////////
   // saturation fit of the guarded result: 48-bit accumulator
   accf_flat_span #(
      .WIDTH(RESULT_W+1),
      .LO(SAT_W_NORMAL-1)
   ) u_fit_normal (
      .word(pre_sat_result),
      .flat(fit_normal)
   );

   // same test for the 32-bit accumulator of sixteen-bit mode
   accf_flat_span #(
      .WIDTH(RESULT_W+1),
      .LO(SAT_W_SIXTEEN-1)
   ) u_fit_sixteen (
      .word(pre_sat_result),
      .flat(fit_sixteen)
   );

   ////////////////////////////////////////////////////////////////////////
   // per-mode extension and unnormalized terms
   always_comb begin
      ext_bit = flags_reg[FLAG_E];
      unn_bit = flags_reg[FLAG_U];
      case (mode)
         SCALE_NONE: begin
            ext_bit = ~int_flat_none;
            unn_bit = unn_none;
         end
         SCALE_DOWN: begin
            ext_bit = ~int_flat_down;
            unn_bit = unn_down;
         end
         SCALE_UP: begin
            ext_bit = ~int_flat_up;
            unn_bit = unn_up;
         end
         default: begin
            // reserved mode: undefined, hold previous values
            ext_bit = flags_reg[FLAG_E];
            unn_bit = flags_reg[FLAG_U];
         end
      endcase
   end

   // saturation overflow and carry source
   always_comb begin
      sat_ovf = sixteen_mode ? ~fit_sixteen : ~fit_normal;
      case (carry_src)
         ACCF_CARRY_ARITH: carry_bit = carry_out;
         ACCF_CARRY_OTHER: carry_bit = other_carry;
         default: carry_bit = flags_reg[FLAG_C];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next flag vector on flag_update: E, U, N, Z from alu_result, V and C from other inputs
   always_comb begin
      flags_next = flags_reg;
      if (flag_update) begin
         flags_next[FLAG_E] = ext_bit;
         flags_next[FLAG_U] = unn_bit;
         flags_next[FLAG_N] = alu_result[RESULT_MSB];
         flags_next[FLAG_Z] = (alu_result == '0);
         flags_next[FLAG_V] = sat_mode ? (arith_overflow | sat_ovf) : arith_overflow;
         flags_next[FLAG_C] = carry_bit;
      end
   end

   // flag register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_reg <= FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // flag outputs straight from the register
   assign flag_extension = flags_reg[FLAG_E];
   assign flag_unnormalized = flags_reg[FLAG_U];
   assign flag_negative = flags_reg[FLAG_N];
   assign flag_zero = flags_reg[FLAG_Z];
   assign flag_overflow = flags_reg[FLAG_V];
   assign flag_carry = flags_reg[FLAG_C];

endmodule

////////////////////////////////////////////////////////////////////////////
// flat-span test: high when bits WIDTH-1 down to LO of a word are all
// ones or all zeros, so the span is only sign extension of bit LO
module accf_flat_span
   import accf_pkg::*;
#(
   parameter int WIDTH = RESULT_W,
   parameter int LO = INT_LO_NONE
) (
   input wire logic [WIDTH-1:0] word,
   output logic flat
);

   logic all_ones;
   logic all_zeros;

   // elaboration check: the span must lie inside the word
   if (WIDTH < 2 || LO < 0 || LO > WIDTH - 1) begin : g_bad_span
      $error("accf_flat_span: span outside the word");
   end

   // and-reduce and nor-reduce of the span, either one means flat
   assign all_ones = &word[WIDTH-1:LO];
   assign all_zeros = ~(|word[WIDTH-1:LO]);
   assign flat = all_ones | all_zeros;

endmodule

// ===== accf_flags_props.sv
`timescale 1ns/1ps
module accf_flags_chk import accf_pkg::*; (
   input logic clk,
   input logic arst_n,
   input logic flag_update,
   input logic [RESULT_W-1:0] alu_result,
   input logic scaling_mode_high,
   input logic scaling_mode_low,
   input logic arith_overflow,
   input logic sat_mode,
   input logic sixteen_mode,
   input logic [RESULT_W:0] pre_sat_result,
   input logic carry_out,
   input accf_carry_src_t carry_src,
   input logic other_carry,
   input logic flag_extension,
   input logic flag_unnormalized,
   input logic flag_negative,
   input logic flag_zero,
   input logic flag_overflow,
   input logic flag_carry
);
   // short aliases for mode, result and flag vector
   wire [1:0] m = {scaling_mode_high, scaling_mode_low};
   wire [55:0] r = alu_result;
   wire u = flag_update;
   wire [5:0] f = {flag_extension, flag_unnormalized, flag_negative, flag_zero, flag_overflow, flag_carry};
   wire [56:0] p = pre_sat_result;
   // expected terms from the rules, sampled one edge back by the properties
   wire flat_none = (&r[55:47]) | (~|r[55:47]);
   wire flat_up = (&r[55:46]) | (~|r[55:46]);
   wire pair_none = r[47] ~^ r[46];
   wire pair_down = r[48] ~^ r[47];
   wire sat48 = arith_overflow | ~((&p[56:47]) | (~|p[56:47]));
   wire sat32 = arith_overflow | ~((&p[56:31]) | (~|p[56:31]));
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // each flag tied to the inputs of the updating edge
   a_ext_flag: assert property (u && m == 0 |=> f[5] == !$past(flat_none)) else $error("bad E");
   a_unnorm_flag: assert property (u && m == 0 |=> f[4] == $past(pair_none)) else $error("bad U");
   a_ext_up: assert property (u && m == 2 |=> f[5] == !$past(flat_up)) else $error("bad E scaled up");
   a_unnorm_down: assert property (u && m == 1 |=> f[4] == $past(pair_down)) else $error("bad U scaled down");
   a_reserved_hold: assert property (u && m == 3 |=> $stable(f[5:4])) else $error("E or U moved");
   a_neg_sign: assert property (u |=> f[3] == $past(r[55])) else $error("bad N");
   a_zero_whole: assert property (u |=> f[2] == ($past(r) == 0)) else $error("bad Z");
   a_ovf_plain: assert property (u && !sat_mode |=> f[1] == $past(arith_overflow)) else $error("bad V");
   a_carry_arith: assert property (u && carry_src == ACCF_CARRY_ARITH |=> f[0] == $past(carry_out))
      else $error("bad C");
   a_idle_hold: assert property (!u |=> $stable(f)) else $error("flags moved");
   a_ovf_sat48: assert property (u && sat_mode && !sixteen_mode |=> f[1] == $past(sat48))
      else $error("bad V saturation 48");
   a_ovf_sat32: assert property (u && sat_mode && sixteen_mode |=> f[1] == $past(sat32))
      else $error("bad V saturation 32");
   a_carry_other: assert property (u && carry_src == ACCF_CARRY_OTHER |=> f[0] == $past(other_carry))
      else $error("bad C other");
endmodule

// ===== accf_flags_tb.sv
`timescale 1ns/1ps
module accf_flags_tb import accf_pkg::*; ;
   logic clk = 0, arst_n = 0, flag_update = 0, scaling_mode_high = 0, scaling_mode_low = 0;
   logic arith_overflow = 0, sat_mode = 0, sixteen_mode = 0, carry_out = 0, other_carry = 0;
   logic flag_extension, flag_unnormalized, flag_negative, flag_zero, flag_overflow, flag_carry;
   logic [55:0] alu_result = 0;
   logic [56:0] pre_sat_result = 0;
   accf_carry_src_t carry_src = ACCF_CARRY_ARITH;
   logic [31:0] seed = 32'h46DD;
   logic [63:0] v, w;
   logic [5:0] exp_f = 6'h20;
   longint s;
   int err_total = 0, cmp_count = 0, lo;
   wire [5:0] got = {flag_extension, flag_unnormalized, flag_negative, flag_zero, flag_overflow, flag_carry};
   accf_flags uut (
      .clk(clk),
      .arst_n(arst_n),
      .flag_update(flag_update),
      .alu_result(alu_result),
      .scaling_mode_high(scaling_mode_high),
      .scaling_mode_low(scaling_mode_low),
      .arith_overflow(arith_overflow),
      .sat_mode(sat_mode),
      .sixteen_mode(sixteen_mode),
      .pre_sat_result(pre_sat_result),
      .carry_out(carry_out),
      .carry_src(carry_src),
      .other_carry(other_carry),
      .flag_extension(flag_extension),
      .flag_unnormalized(flag_unnormalized),
      .flag_negative(flag_negative),
      .flag_zero(flag_zero),
      .flag_overflow(flag_overflow),
      .flag_carry(flag_carry)
   );
   always #2.5 clk = ~clk;
   // xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(logic [5:0] g, logic [5:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task summarize();
      $display("compares=%0d errors=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // random ops, mid-run reset, model compared every cycle
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1;
      for (int i = 0; i < 900; i++) begin
         @(posedge clk);
         v = {rnd(), rnd()};
         w = {rnd(), rnd()};
         flag_update <= (v[6] | v[7]) & !(i inside {[299:302]});
         {scaling_mode_high, scaling_mode_low, arith_overflow, sat_mode, sixteen_mode} <= v[4:0];
         alu_result <= v[9:8] == 0 ? 56'h0 : v[9] ? w[55:0] : {{16{w[39]}}, w[39:0]};
         pre_sat_result <= v[10] ? {{25{w[31]}}, w[31:0]} : v[11] ? {{9{w[47]}}, w[47:0]} : w[56:0];
         {carry_out, other_carry} <= v[13:12];
         carry_src <= accf_carry_src_t'(v[15:14] % 2'h3);
         if (i == 300 || i == 302) arst_n <= i == 302;
         #1 chk(got, exp_f);
         if (flag_update) begin
            lo = scaling_mode_low ? 48 : scaling_mode_high ? 46 : 47;
            s = alu_result >> lo;
            if (!(scaling_mode_high & scaling_mode_low))
               exp_f[5:4] = {s != 0 && s != (64'd1 << (56 - lo)) - 1, alu_result[lo] ~^ alu_result[lo - 1]};
            s = $signed(pre_sat_result);
            exp_f[3] = alu_result[55];
            exp_f[2] = alu_result == 0;
            exp_f[1] = arith_overflow | sat_mode & !((s >>> (sixteen_mode ? 31 : 47)) inside {0, -1});
            if (carry_src != ACCF_CARRY_HOLD) exp_f[0] = carry_src == ACCF_CARRY_ARITH ? carry_out : other_carry;
         end
         if (i inside {[299:301]}) exp_f = 6'h20;
      end
      summarize();
   end
endmodule
bind accf_flags accf_flags_chk chk (
   .clk(clk),
   .arst_n(arst_n),
   .flag_update(flag_update),
   .alu_result(alu_result),
   .scaling_mode_high(scaling_mode_high),
   .scaling_mode_low(scaling_mode_low),
   .arith_overflow(arith_overflow),
   .sat_mode(sat_mode),
   .sixteen_mode(sixteen_mode),
   .pre_sat_result(pre_sat_result),
   .carry_out(carry_out),
   .carry_src(carry_src),
   .other_carry(other_carry),
   .flag_extension(flag_extension),
   .flag_unnormalized(flag_unnormalized),
   .flag_negative(flag_negative),
   .flag_zero(flag_zero),
   .flag_overflow(flag_overflow),
   .flag_carry(flag_carry)
);
